// file: common/rtl_line_defs.vh
// Constants for the real-time trigger line evaluator
// Summary of operation
// - A window-test line continuously sets its target bit when low < value < high, else clears it.
// - Window test takes value, low and high as register descriptors and the target as a bit descriptor.
// - A continuous-calculation line writes op(first, second) into the third register, except for operations 0 and 12 to 15 and division by zero.
// - Operation 0 does nothing, 1 adds, 2 subtracts, 3 multiplies and 4 divides first by second.
// - Operations 5 to 9 are NOT first, AND, OR, first AND NOT second, first OR NOT second.
// - Operation 10 shifts the first right by the second, 11 shifts it left, into the third register.
// - A simple-clock line adds one to its first register on every slow tick.
// - The simple clock requests its label jump when the count exceeds the maximum register.
// - Clock bit modes: 0 leaves the bit, 1 sets it at count >= max, 2 clears it at count < max, 3 toggles it.
// - A brake line with polarity 1 or 2 drives its bit from ready = drive status bit 10 clear, bits 1 and 0 set.
// - Brake combine: 0 ready alone, 1 AND ctl, 2 OR ctl, 3 AND NOT ctl, 4 OR NOT ctl.
// - Brake polarity: 0 leaves the bit, 1 writes the result, 2 writes its inverse.
// - A line runs only when marked valid, enabled and the trigger-enable mode has been commanded.
`ifndef RTL_LINE_DEFS_VH
`define RTL_LINE_DEFS_VH

// Register map, byte addresses
`define OFS_CTRL        12'h000
`define OFS_CMD         12'h004
`define OFS_STATUS      12'h008
`define OFS_TYPE        12'h00C
`define OFS_LABEL       12'h010
`define OFS_PARAM1      12'h014
`define OFS_PARAM2      12'h018
`define OFS_PARAM3      12'h01C
`define OFS_PARAM4      12'h020
`define OFS_VAR_BASE    12'h100
`define VAR_PAGE_MASK   12'hF00
`define VAR_IDX_LSB     2
`define VAR_IDX_MSB     5

// Variable space
`define VAR_IDX_W       4
`define NUM_VARS        16

// Control, status and command fields
`define CTRL_VALID_BIT  0
`define CTRL_ENABLE_BIT 1
`define STAT_MODE_BIT   0
`define STAT_JUMP_BIT   1
`define CMD_ENTER       32'h0000_0001
`define CMD_LEAVE       32'h0000_0002

// Descriptor fields
`define RD_IDX_MSB      3
`define BD_POS_MSB      4
`define BD_IDX_LSB      8
`define BD_IDX_MSB      11

// Line type codes
`define TYPE_WINDOW     8'h16
`define TYPE_CALC       8'h1E
`define TYPE_CLOCK      8'h28
`define TYPE_BRAKE      8'h32

// Calculation codes
`define OP_NONE         4'h0
`define OP_ADD          4'h1
`define OP_SUB          4'h2
`define OP_MUL          4'h3
`define OP_DIV          4'h4
`define OP_NOT          4'h5
`define OP_AND          4'h6
`define OP_OR           4'h7
`define OP_ANDN         4'h8
`define OP_ORN          4'h9
`define OP_SHR          4'hA
`define OP_SHL          4'hB

// Clock bit-action and brake modes
`define CLK_KEEP        3'h0
`define CLK_SET         3'h1
`define CLK_CLEAR       3'h2
`define CLK_TOGGLE      3'h3
`define BRK_READY       3'h0
`define BRK_AND         3'h1
`define BRK_OR          3'h2
`define BRK_ANDN        3'h3
`define BRK_ORN         3'h4
`define POL_KEEP        3'h0
`define POL_DIRECT      3'h1
`define POL_INVERT      3'h2

// Drive status bits forming the ready term
`define DS_FAULT_BIT    10
`define DS_PH1_BIT      1
`define DS_PH0_BIT      0

// Slow tick period in clock cycles
`define STI_CYCLES      1000

`endif

// file: verilog/realtime_line_calc.v
// Arithmetic, logic and shift unit of the continuous-calculation line
`timescale 1ns/1ps
`include "rtl_line_defs.vh"
module realtime_line_calc #(
    parameter W = 32
) (
    input  wire [3:0]   op_in,
    input  wire [W-1:0] a_in,
    input  wire [W-1:0] b_in,
    output reg  [W-1:0] res_out,
    output reg          ok_out
);
    wire [2*W-1:0] prod = a_in * b_in;
    wire           big_shift = (b_in >= W);

    // Result select; ok low means leave the target register alone
    always @* begin
        ok_out  = 1'b1;
        res_out = {W{1'b0}};
        case (op_in)
            `OP_ADD:  res_out = a_in + b_in;
            `OP_SUB:  res_out = a_in - b_in;
            `OP_MUL:  res_out = prod[W-1:0];
            `OP_DIV: begin
                ok_out  = (b_in != {W{1'b0}});
                res_out = ok_out ? $unsigned($signed(a_in) / $signed(b_in)) : a_in;
            end
            `OP_NOT:  res_out = ~a_in;
            `OP_AND:  res_out = a_in & b_in;
            `OP_OR:   res_out = a_in | b_in;
            `OP_ANDN: res_out = a_in & ~b_in;
            `OP_ORN:  res_out = a_in | ~b_in;
            `OP_SHR:  res_out = big_shift ? {W{1'b0}} : a_in >> b_in;
            `OP_SHL:  res_out = big_shift ? {W{1'b0}} : a_in << b_in;
            default:  ok_out  = 1'b0;
        endcase
    end
endmodule

// file: verilog/realtime_line_evaluator.v
// Real-time trigger line evaluator with APB register access
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "rtl_line_defs.vh"
module realtime_line_evaluator #(
    parameter STI_CYCLES = `STI_CYCLES
) (
    input  wire        SYS_CLK_IN,
    input  wire        ARST_N_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [11:0] PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output wire [31:0] PRDATA_OUT,
    output wire        PREADY_OUT,
    output wire        PSLVERR_OUT,
    input  wire [15:0] DRIVE_STATUS_IN,
    output wire        JUMP_REQ_OUT,
    output wire [31:0] JUMP_LABEL_OUT,
    output wire        TRIG_MODE_OUT,
    output wire [31:0] DIGITAL_OUT_OUT
);
    // One-hot sequencer states for the simple clock
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_INC = 3'b010;
    localparam [2:0] ST_BIT = 3'b100;

    reg  [31:0] var_mem [0:`NUM_VARS-1];
    reg         line_valid_flag_ff;
    reg         line_enable_flag_ff;
    reg         trig_mode_ff;
    reg         jump_flag_ff;
    reg         jump_req_ff;
    reg  [7:0]  line_type_ff;
    reg  [31:0] label_ff;
    reg  [31:0] param1_ff;
    reg  [31:0] param2_ff;
    reg  [31:0] param3_ff;
    reg  [31:0] param4_ff;
    reg  [31:0] prdata_ff;
    reg         pslverr_ff;
    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg         tick_pend_ff;
    reg  [31:0] tick_cnt_ff;
    reg         eval_we;
    reg  [`VAR_IDX_W-1:0] eval_idx;
    reg  [31:0] eval_data;
    reg         jump_hit;
    reg  [31:0] rd_word;
    reg         rd_hit;
    integer     i;

    // APB decode
    wire        setup    = PSEL_IN & ~PENABLE_IN;
    wire        access   = PSEL_IN & PENABLE_IN;
    wire        wr       = access & PWRITE_IN;
    wire        var_sel  = (PADDR_IN & `VAR_PAGE_MASK) == `OFS_VAR_BASE;
    wire        var_ok   = var_sel && (PADDR_IN[1:0] == 2'h0)
                           && (PADDR_IN[7:6] == 2'h0);
    wire [`VAR_IDX_W-1:0] var_idx = PADDR_IN[`VAR_IDX_MSB:`VAR_IDX_LSB];
    wire        apb_var_we = wr & var_ok;

    // Descriptor decode
    wire [`VAR_IDX_W-1:0] rd1 = param1_ff[`RD_IDX_MSB:0];
    wire [`VAR_IDX_W-1:0] rd2 = param2_ff[`RD_IDX_MSB:0];
    wire [`VAR_IDX_W-1:0] rd3 = param3_ff[`RD_IDX_MSB:0];
    wire [31:0] v1 = var_mem[rd1];
    wire [31:0] v2 = var_mem[rd2];
    wire [31:0] v3 = var_mem[rd3];
    wire [`VAR_IDX_W-1:0] bd1_idx = param1_ff[`BD_IDX_MSB:`BD_IDX_LSB];
    wire [4:0]  bd1_pos = param1_ff[`BD_POS_MSB:0];
    wire [`VAR_IDX_W-1:0] bd3_idx = param3_ff[`BD_IDX_MSB:`BD_IDX_LSB];
    wire [4:0]  bd3_pos = param3_ff[`BD_POS_MSB:0];
    wire [`VAR_IDX_W-1:0] bd4_idx = param4_ff[`BD_IDX_MSB:`BD_IDX_LSB];
    wire [4:0]  bd4_pos = param4_ff[`BD_POS_MSB:0];
    wire [31:0] w3 = var_mem[bd3_idx];
    wire [31:0] w4 = var_mem[bd4_idx];

    // Line runs only when valid, enabled and in trigger-enable mode
    wire        active = line_valid_flag_ff & line_enable_flag_ff & trig_mode_ff;

    // Window comparison on signed variables
    wire        in_window = ($signed(v2) < $signed(v1))
                            && ($signed(v1) < $signed(v3));

    // Drive-ready term from the drive status word
    wire        drv_ready = ~DRIVE_STATUS_IN[`DS_FAULT_BIT] & DRIVE_STATUS_IN[`DS_PH1_BIT]
                            & DRIVE_STATUS_IN[`DS_PH0_BIT];
    wire        ext_ctl   = var_mem[bd1_idx][bd1_pos];

    // Simple clock compare against the maximum register
    wire        cnt_above  = $signed(v1) > $signed(v2);
    wire        cnt_at_max = $signed(v1) >= $signed(v2);

    wire [31:0] calc_res;
    wire        calc_ok;

    // Calculation unit for type 30
    realtime_line_calc #(
        .W       (32)
    ) realtime_line_calc_inst (
        .op_in   (param4_ff[3:0]),
        .a_in    (v1),
        .b_in    (v2),
        .res_out (calc_res),
        .ok_out  (calc_ok)
    );

    // Returns a word with one bit replaced
    function [31:0] put_bit;
        input [31:0] word;
        input [4:0]  pos;
        input        val;
        begin
            put_bit = word;
            put_bit[pos] = val;
        end
    endfunction

    // Brake combine of the ready term with the control bit
    reg brk_comb;
    always @* begin
        case (param2_ff[2:0])
            `BRK_READY: brk_comb = drv_ready;
            `BRK_AND:   brk_comb = drv_ready & ext_ctl;
            `BRK_OR:    brk_comb = drv_ready | ext_ctl;
            `BRK_ANDN:  brk_comb = drv_ready & ~ext_ctl;
            `BRK_ORN:   brk_comb = drv_ready | ~ext_ctl;
            default:    brk_comb = drv_ready;
        endcase
    end

    // Evaluation: one variable write per cycle, only when the value changes
    always @* begin
        eval_we   = 1'b0;
        eval_idx  = {`VAR_IDX_W{1'b0}};
        eval_data = 32'h0000_0000;
        jump_hit  = 1'b0;
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (active && line_type_ff == `TYPE_WINDOW) begin
                    eval_idx  = bd4_idx;
                    eval_data = put_bit(w4, bd4_pos, in_window);
                    eval_we   = (eval_data != w4);
                end else if (active && line_type_ff == `TYPE_CALC) begin
                    eval_idx  = rd3;
                    eval_data = calc_res;
                    eval_we   = calc_ok && (calc_res != v3);
                end else if (active && line_type_ff == `TYPE_BRAKE) begin
                    eval_idx  = bd3_idx;
                    if (param4_ff[2:0] == `POL_DIRECT) begin
                        eval_data = put_bit(w3, bd3_pos, brk_comb);
                    end else if (param4_ff[2:0] == `POL_INVERT) begin
                        eval_data = put_bit(w3, bd3_pos, ~brk_comb);
                    end else begin
                        eval_data = w3;
                    end
                    eval_we   = (eval_data != w3);
                end else if (active && line_type_ff == `TYPE_CLOCK && tick_pend_ff) begin
                    nxt_state = ST_INC;
                end
            end
            ST_INC: begin
                eval_idx  = rd1;
                eval_data = v1 + 32'h0000_0001;
                eval_we   = active;
                if (!active || !apb_var_we) begin
                    nxt_state = active ? ST_BIT : ST_RUN;
                end
            end
            ST_BIT: begin
                eval_idx  = bd3_idx;
                eval_data = w3;
                case (param4_ff[2:0])
                    `CLK_SET:    if (cnt_at_max) eval_data = put_bit(w3, bd3_pos, 1'b1);
                    `CLK_CLEAR:  if (!cnt_at_max) eval_data = put_bit(w3, bd3_pos, 1'b0);
                    `CLK_TOGGLE: eval_data = put_bit(w3, bd3_pos, ~w3[bd3_pos]);
                    default:     eval_data = w3;
                endcase
                eval_we   = active && (eval_data != w3);
                if (!active || !apb_var_we) begin
                    jump_hit  = active && cnt_above;
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    // Variable space: bus writes win, evaluation retries next cycle
    always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            for (i = 0; i < `NUM_VARS; i = i + 1) begin
                var_mem[i] <= 32'h0000_0000;
            end
        end else if (apb_var_we) begin
            var_mem[var_idx] <= PWDATA_IN;
        end else if (eval_we) begin
            var_mem[eval_idx] <= eval_data;
        end
    end

    // Slow tick divider and pending tick for the simple clock
    always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            tick_cnt_ff  <= 32'h0000_0000;
            tick_pend_ff <= 1'b0;
            state_ff     <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
            if (tick_cnt_ff == STI_CYCLES - 1) begin
                tick_cnt_ff  <= 32'h0000_0000;
                tick_pend_ff <= 1'b1;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
                if (state_ff == ST_BIT && nxt_state == ST_RUN) begin
                    tick_pend_ff <= 1'b0;
                end else if (!(active && line_type_ff == `TYPE_CLOCK)) begin
                    tick_pend_ff <= 1'b0;
                end
            end
        end
    end

    // Read mux for the setup phase
    always @* begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        if (var_sel) begin
            rd_hit  = var_ok;
            rd_word = var_ok ? var_mem[var_idx] : 32'h0000_0000;
        end else begin
            case (PADDR_IN)
                `OFS_CTRL: begin
                    rd_word[`CTRL_VALID_BIT]  = line_valid_flag_ff;
                    rd_word[`CTRL_ENABLE_BIT] = line_enable_flag_ff;
                end
                `OFS_CMD:    rd_word = 32'h0000_0000;
                `OFS_STATUS: begin
                    rd_word[`STAT_MODE_BIT] = trig_mode_ff;
                    rd_word[`STAT_JUMP_BIT] = jump_flag_ff;
                end
                `OFS_TYPE:   rd_word = {24'h00_0000, line_type_ff};
                `OFS_LABEL:  rd_word = label_ff;
                `OFS_PARAM1: rd_word = param1_ff;
                `OFS_PARAM2: rd_word = param2_ff;
                `OFS_PARAM3: rd_word = param3_ff;
                `OFS_PARAM4: rd_word = param4_ff;
                default:     rd_hit  = 1'b0;
            endcase
        end
    end

    // Control registers, command and sticky jump flag
    always @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            line_valid_flag_ff  <= 1'b0;
            line_enable_flag_ff <= 1'b0;
            trig_mode_ff        <= 1'b0;
            jump_flag_ff        <= 1'b0;
            jump_req_ff         <= 1'b0;
            line_type_ff        <= 8'h00;
            label_ff            <= 32'h0000_0000;
            param1_ff           <= 32'h0000_0000;
            param2_ff           <= 32'h0000_0000;
            param3_ff           <= 32'h0000_0000;
            param4_ff           <= 32'h0000_0000;
            prdata_ff           <= 32'h0000_0000;
            pslverr_ff          <= 1'b0;
        end else begin
            jump_req_ff <= jump_hit;
            if (setup) begin
                prdata_ff  <= PWRITE_IN ? 32'h0000_0000 : rd_word;
                pslverr_ff <= ~rd_hit;
            end
            if (wr && !var_sel) begin
                case (PADDR_IN)
                    `OFS_CTRL: begin
                        line_valid_flag_ff  <= PWDATA_IN[`CTRL_VALID_BIT];
                        line_enable_flag_ff <= PWDATA_IN[`CTRL_ENABLE_BIT];
                    end
                    `OFS_CMD: begin
                        if (PWDATA_IN == `CMD_ENTER) begin
                            trig_mode_ff <= 1'b1;
                        end else if (PWDATA_IN == `CMD_LEAVE) begin
                            trig_mode_ff <= 1'b0;
                        end
                    end
                    `OFS_TYPE:   line_type_ff <= PWDATA_IN[7:0];
                    `OFS_LABEL:  label_ff     <= PWDATA_IN;
                    `OFS_PARAM1: param1_ff    <= PWDATA_IN;
                    `OFS_PARAM2: param2_ff    <= PWDATA_IN;
                    `OFS_PARAM3: param3_ff    <= PWDATA_IN;
                    `OFS_PARAM4: param4_ff    <= PWDATA_IN;
                    default:     param4_ff    <= param4_ff;
                endcase
            end
            // Set wins over a write-one clear in the same cycle
            if (jump_hit) begin
                jump_flag_ff <= 1'b1;
            end else if (wr && PADDR_IN == `OFS_STATUS && PWDATA_IN[`STAT_JUMP_BIT]) begin
                jump_flag_ff <= 1'b0;
            end
        end
    end

    // Outputs
    assign PRDATA_OUT      = prdata_ff;
    assign PREADY_OUT      = 1'b1;          // Zero wait states
    assign PSLVERR_OUT     = access & pslverr_ff;
    assign JUMP_REQ_OUT    = jump_req_ff;
    assign JUMP_LABEL_OUT  = label_ff;
    assign TRIG_MODE_OUT   = trig_mode_ff;
    assign DIGITAL_OUT_OUT = var_mem[0];
endmodule

// file: tb/realtime_line_evaluator_props.sv
// Port checker for the real-time trigger line evaluator
`timescale 1ns/1ps
`include "rtl_line_defs.vh"
module realtime_line_evaluator_props #(
    parameter STI_CYCLES = 10
) (
    input wire        SYS_CLK_IN,
    input wire        ARST_N_IN,
    input wire        PSEL_IN,
    input wire        PENABLE_IN,
    input wire        PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire        PREADY_OUT,
    input wire        PSLVERR_OUT,
    input wire        JUMP_REQ_OUT,
    input wire [31:0] JUMP_LABEL_OUT,
    input wire        TRIG_MODE_OUT,
    input wire [31:0] DIGITAL_OUT_OUT
);
    // Access phase and committed write
    wire acc = PSEL_IN && PENABLE_IN;
    wire wr  = acc && PWRITE_IN;
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    ready_always_a: assert property (PREADY_OUT) else $error("ready low");
    err_phase_a: assert property (PSLVERR_OUT |-> acc) else $error("error outside access");
    unmapped_err_a: assert property (acc && PADDR_IN[11:8] == 4'h1 && PADDR_IN[7:6] != 2'h0
        |-> PSLVERR_OUT) else $error("unmapped access accepted");
    mapped_ok_a: assert property (acc && PADDR_IN == `OFS_CTRL |-> !PSLVERR_OUT)
        else $error("control access refused");
    mode_enter_a: assert property ($rose(TRIG_MODE_OUT) |->
        $past(wr && PADDR_IN == `OFS_CMD && PWDATA_IN == `CMD_ENTER)) else $error("mode set");
    mode_leave_a: assert property ($fell(TRIG_MODE_OUT) |->
        $past(wr && PADDR_IN == `OFS_CMD && PWDATA_IN == `CMD_LEAVE)) else $error("mode lost");
    jump_pulse_a: assert property (JUMP_REQ_OUT |=> !JUMP_REQ_OUT [*8])
        else $error("jump pulse too long");
    label_copy_a: assert property (wr && PADDR_IN == `OFS_LABEL |=>
        JUMP_LABEL_OUT == $past(PWDATA_IN)) else $error("label not copied");
    digital_hold_a: assert property (!TRIG_MODE_OUT && !(wr && PADDR_IN == `OFS_VAR_BASE)
        |=> $stable(DIGITAL_OUT_OUT)) else $error("outputs moved while idle");
    cover property (JUMP_REQ_OUT);
    cover property ($rose(TRIG_MODE_OUT));
    cover property (PSLVERR_OUT);
endmodule

bind realtime_line_evaluator realtime_line_evaluator_props #(.STI_CYCLES(STI_CYCLES)) props_inst (
    .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .JUMP_REQ_OUT(JUMP_REQ_OUT), .JUMP_LABEL_OUT(JUMP_LABEL_OUT),
    .TRIG_MODE_OUT(TRIG_MODE_OUT), .DIGITAL_OUT_OUT(DIGITAL_OUT_OUT));

// file: tb/realtime_line_evaluator_test.sv
// Self-checking bench for the real-time trigger line evaluator
`timescale 1ns/1ps
`include "rtl_line_defs.vh"
module realtime_line_evaluator_test;
    localparam int STI = 10;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, jump_req, trig_mode;
    logic        berr, bit_prev, rdy, comb;
    logic [11:0] paddr;
    logic [15:0] dstat;
    logic [31:0] pwdata, prdata, rdata, jump_label, dout, cnt_saved;
    logic [31:0] calc_exp [0:11];
    logic [31:0] win_val [0:4];
    int          err_count, samples_checked;

    // Device with a short slow tick
    realtime_line_evaluator #(.STI_CYCLES(STI)) realtime_line_evaluator_inst (
        .SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .DRIVE_STATUS_IN(dstat),
        .JUMP_REQ_OUT(jump_req), .JUMP_LABEL_OUT(jump_label), .TRIG_MODE_OUT(trig_mode),
        .DIGITAL_OUT_OUT(dout));

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        final_report();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        berr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    function automatic logic [11:0] va(input int i);
        return `OFS_VAR_BASE + 12'(i * 4);
    endfunction
    // Configure one line with the line disabled meanwhile
    task automatic line(input logic [7:0] t, input logic [31:0] p1, p2, p3, p4);
        wr(`OFS_CTRL, 32'h0);
        wr(`OFS_TYPE, {24'h0, t});
        wr(`OFS_PARAM1, p1);
        wr(`OFS_PARAM2, p2);
        wr(`OFS_PARAM3, p3);
        wr(`OFS_PARAM4, p4);
        wr(`OFS_CTRL, 32'h3);
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        dstat = 16'h0000;
        err_count = 0;
        samples_checked = 0;
        calc_exp = '{32'h55, 32'hF10, 32'hF08, 32'h3C30, 32'h3C3, 32'hFFFFF0F3, 32'h4, 32'hF0C,
            32'hF08, 32'hFFFFFFFF, 32'hF0, 32'hF0C0};
        win_val = '{32'hFFFFFFF6, 32'hFFFFFFF7, 32'h27, 32'h28, 32'h0};
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values and refused places
        rd_chk(`OFS_CTRL, 32'h0);
        chk({31'h0, berr}, 32'h0);
        rd_chk(`OFS_STATUS, 32'h0);
        rd_chk(`OFS_VAR_BASE, 32'h0);
        rd_chk(12'h140, 32'h0);
        chk({31'h0, berr}, 32'h1);
        rd_chk(12'h102, 32'h0);
        chk({31'h0, berr}, 32'h1);
        wr(`OFS_CMD, `CMD_ENTER);
        rd_chk(`OFS_STATUS, 32'h1);
        chk({31'h0, trig_mode}, 32'h1);
        $display("test registers done");
        // Window with a negative lower limit
        wr(va(2), 32'hFFFFFFF6);
        wr(va(3), 32'h28);
        line(`TYPE_WINDOW, 32'h1, 32'h2, 32'h3, 32'h005);
        foreach (win_val[i]) begin
            wr(va(1), win_val[i]);
            repeat (3) @(posedge clk);
            rdy = ($signed(win_val[i]) > -10) && ($signed(win_val[i]) < 40);
            chk({31'h0, dout[5]}, {31'h0, rdy});
        end
        $display("test window done");
        // Every calculation code, then a division by zero
        line(`TYPE_CALC, 32'h1, 32'h2, 32'h3, 32'h0);
        wr(va(1), 32'hF0C);
        wr(va(2), 32'h4);
        wr(va(3), 32'h55);
        for (int op = 0; op < 12; op++) begin
            wr(`OFS_PARAM4, 32'(op));
            repeat (3) @(posedge clk);
            rd_chk(va(3), calc_exp[op]);
        end
        wr(`OFS_PARAM4, 32'h4);
        wr(va(1), 32'hFFFFFFF8);
        repeat (3) @(posedge clk);
        rd_chk(va(3), 32'hFFFFFFFE);
        wr(va(2), 32'h0);
        repeat (3) @(posedge clk);
        rd_chk(va(3), 32'hFFFFFFFE);
        $display("test calc done");
        // Brake over polarity, combine mode, control bit and drive status
        line(`TYPE_BRAKE, 32'h400, 32'h0, 32'h007, 32'h1);
        for (int p = 1; p < 3; p++) for (int m = 0; m < 5; m++) for (int c = 0; c < 2; c++)
            for (int r = 0; r < 3; r++) begin
                wr(`OFS_PARAM4, 32'(p));
                wr(`OFS_PARAM2, 32'(m));
                wr(va(4), 32'(c));
                dstat <= (r == 0) ? 16'h0003 : (r == 1) ? 16'h0403 : 16'h0001;
                repeat (3) @(posedge clk);
                rdy = (r == 0);
                case (m)
                    1: comb = rdy & c[0];
                    2: comb = rdy | c[0];
                    3: comb = rdy & ~c[0];
                    4: comb = rdy | ~c[0];
                    default: comb = rdy;
                endcase
                chk({31'h0, dout[7]}, {31'h0, comb ^ (p == 2)});
            end
        wr(`OFS_PARAM2, 32'h0);
        wr(`OFS_PARAM4, 32'h0);
        dstat <= 16'h0003;
        repeat (3) @(posedge clk);
        chk({31'h0, dout[7]}, 32'h1);
        dstat <= 16'h0000;
        repeat (3) @(posedge clk);
        chk({31'h0, dout[7]}, 32'h1);
        $display("test brake done");
        // Simple clock: count, jump, then each bit mode
        wr(va(5), 32'h0);
        wr(va(6), 32'h3);
        wr(`OFS_LABEL, 32'h32);
        line(`TYPE_CLOCK, 32'h5, 32'h6, 32'h009, 32'h1);
        for (int n = 0; n < 100 && jump_req !== 1'b1; n++) @(posedge clk);
        chk({31'h0, jump_req}, 32'h1);
        chk(jump_label, 32'h32);
        rd_chk(va(5), 32'h4);
        chk({31'h0, dout[9]}, 32'h1);
        rd_chk(`OFS_STATUS, 32'h3);
        wr(va(6), 32'h7FFFFFFF);
        wr(`OFS_STATUS, 32'h2);
        rd_chk(`OFS_STATUS, 32'h1);
        wr(`OFS_PARAM4, 32'h2);
        repeat (2 * STI + 5) @(posedge clk);
        chk({31'h0, dout[9]}, 32'h0);
        wr(`OFS_PARAM4, 32'h3);
        repeat (STI + 5) @(posedge clk);
        #1 bit_prev = dout[9];
        repeat (STI) @(posedge clk);
        #1 chk({31'h0, dout[9]}, {31'h0, ~bit_prev});
        wr(`OFS_PARAM4, 32'h0);
        #1 bit_prev = dout[9];
        repeat (2 * STI) @(posedge clk);
        chk({31'h0, dout[9]}, {31'h0, bit_prev});
        $display("test clock done");
        // No counting outside the mode or without the valid flag
        wr(`OFS_CMD, `CMD_LEAVE);
        rd_chk(`OFS_STATUS, 32'h0);
        chk({31'h0, trig_mode}, 32'h0);
        apb(1'b0, va(5), 32'h0);
        cnt_saved = rdata;
        repeat (3 * STI) @(posedge clk);
        rd_chk(va(5), cnt_saved);
        wr(`OFS_CTRL, 32'h2);
        wr(`OFS_CMD, `CMD_ENTER);
        repeat (3 * STI) @(posedge clk);
        rd_chk(va(5), cnt_saved);
        wr(`OFS_CTRL, 32'h3);
        repeat (2 * STI + 5) @(posedge clk);
        apb(1'b0, va(5), 32'h0);
        chk({31'h0, rdata > cnt_saved}, 32'h1);
        $display("test gating done");
        final_report();
    end
endmodule
